// *** hdl/nvs_host.sv ***
// Purpose: Host controller driving a nonvolatile SRAM through its pins.
// Assumes: One command at a time; supply_ok and dq_in arrive asynchronously.
// Notes: Store and recall are issued as uninterruptible six-read sequences.
`timescale 1ns/10ps
`default_nettype none
`include "nvs_map.svh"

module nvs_host #(
   parameter int STORE_CYC = `NVS_STORE_CYC,
   parameter int RESTORE_CYC = `NVS_RESTORE_CYC
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic cmd_valid,
   input wire nvs_pkg::nvs_cmd_t cmd,
   output logic cmd_ready,
   output logic rsp_valid,
   output logic rsp_err,
   output logic [7:0] rsp_data,
   output logic busy,
   input wire logic supply_ok,
   input wire logic [7:0] dq_in,
   output nvs_pkg::nvs_pins_t pins
);

   if (STORE_CYC < 1 || STORE_CYC >= (1 << `NVS_CNT_W) || RESTORE_CYC < 1 ||
       RESTORE_CYC >= (1 << `NVS_CNT_W)) begin : g_chk
      $error("nvs_host: wait counts out of counter range");
   end

   localparam logic [`NVS_CNT_W-1:0] STORE_W = `NVS_CNT_W'(STORE_CYC - 1);
   localparam logic [`NVS_CNT_W-1:0] RESTORE_W = `NVS_CNT_W'(RESTORE_CYC - 1);
   localparam logic [`NVS_CNT_W-1:0] RECALL_W = `NVS_CNT_W'(`NVS_RECALL_CYC - 1);
   localparam logic [`NVS_CNT_W-1:0] STROBE_W = `NVS_CNT_W'(`NVS_STROBE_CYC - 1);

   function automatic logic [12:0] seq_addr(input logic [2:0] idx, input nvs_pkg::nvs_op_t op);
      case (idx)
         3'h0: seq_addr = `NVS_SEQ_A0;
         3'h1: seq_addr = `NVS_SEQ_A1;
         3'h2: seq_addr = `NVS_SEQ_A2;
         3'h3: seq_addr = `NVS_SEQ_A3;
         3'h4: seq_addr = `NVS_SEQ_A4;
         default: seq_addr = (op == nvs_pkg::op_store) ? `NVS_SEQ_STORE : `NVS_SEQ_RECALL;
      endcase
   endfunction : seq_addr

   nvs_pkg::nvs_state_t state;
   nvs_pkg::nvs_state_t next_state;
   nvs_pkg::nvs_cmd_t cur;
   logic [`NVS_CNT_W-1:0] cnt;
   logic [2:0] seq_idx;
   logic seq;
   logic sup1, sup2, sup3, supply_ok_q;
   logic [7:0] dq1, dq2, dq3, dq_stable;
   logic accept;
   logic is_nv;

   assign accept = cmd_valid && cmd_ready;
   assign is_nv = (cmd.op == nvs_pkg::op_store) || (cmd.op == nvs_pkg::op_recall);

   // Three-stage sync; a change counts once stages two and three agree
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sup1 <= 1'b0;
         sup2 <= 1'b0;
         sup3 <= 1'b0;
         supply_ok_q <= 1'b0;
         dq1 <= 8'h00;
         dq2 <= 8'h00;
         dq3 <= 8'h00;
         dq_stable <= 8'h00;
      end else begin
         sup1 <= supply_ok;
         sup2 <= sup1;
         sup3 <= sup2;
         dq1 <= dq_in;
         dq2 <= dq1;
         dq3 <= dq2;
         if (sup2 == sup3) begin
            supply_ok_q <= sup3;
         end
         if (dq2 == dq3) begin
            dq_stable <= dq3;
         end
      end
   end

   always_comb begin
      next_state = state;
      case (state)
         nvs_pkg::st_pwrup: begin
            if (supply_ok_q && cnt == RESTORE_W) begin
               next_state = nvs_pkg::st_idle;
            end
         end
         nvs_pkg::st_idle: begin
            if (accept) begin
               if (cmd.op == nvs_pkg::op_store && !supply_ok_q) begin
                  next_state = nvs_pkg::st_idle;
               end else begin
                  next_state = nvs_pkg::st_setup;
               end
            end else if (!supply_ok_q) begin
               next_state = nvs_pkg::st_pwrup;
            end
         end
         nvs_pkg::st_setup: next_state = nvs_pkg::st_strobe;
         nvs_pkg::st_strobe: begin
            if (cnt == STROBE_W) begin
               next_state = nvs_pkg::st_end;
            end
         end
         nvs_pkg::st_end: begin
            // Steps follow back to back; nothing else may slip in
            if (seq && seq_idx != `NVS_SEQ_LAST) begin
               next_state = nvs_pkg::st_setup;
            end else if (seq) begin
               next_state = nvs_pkg::st_nvwait;
            end else begin
               next_state = nvs_pkg::st_idle;
            end
         end
         nvs_pkg::st_nvwait: begin
            if (cnt == ((cur.op == nvs_pkg::op_store) ? STORE_W : RECALL_W)) begin
               next_state = nvs_pkg::st_idle;
            end
         end
         default: next_state = nvs_pkg::st_pwrup;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state <= nvs_pkg::st_pwrup;
      end else begin
         state <= next_state;
      end
   end

   // Power-up wait restarts whenever the supply dips again
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= '0;
      end else if (next_state != state || (state == nvs_pkg::st_pwrup && !supply_ok_q)) begin
         cnt <= '0;
      end else begin
         cnt <= cnt + 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cur <= '0;
         seq <= 1'b0;
         seq_idx <= 3'h0;
      end else if (state == nvs_pkg::st_idle && next_state == nvs_pkg::st_setup) begin
         cur <= cmd;
         seq <= is_nv;
         seq_idx <= 3'h0;
      end else if (state == nvs_pkg::st_end && next_state == nvs_pkg::st_setup) begin
         seq_idx <= 3'(seq_idx + 1'b1);
      end else if (next_state == nvs_pkg::st_idle) begin
         seq <= 1'b0;
      end
   end

   // Pins change only on state edges, so address is settled before select falls
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pins <= '{e_n: 1'b1, g_n: 1'b1, w_n: 1'b1, addr: 13'h0000, dq_out: 8'h00, dq_oe: 1'b0};
      end else begin
         pins.e_n <= !(next_state == nvs_pkg::st_strobe);
         pins.w_n <= !(next_state == nvs_pkg::st_strobe && !seq && cur.op == nvs_pkg::op_write);
         pins.g_n <= !(next_state == nvs_pkg::st_strobe && cur.op != nvs_pkg::op_write);
         pins.dq_oe <= next_state == nvs_pkg::st_strobe && !seq && cur.op == nvs_pkg::op_write;
         if (state == nvs_pkg::st_idle && next_state == nvs_pkg::st_setup) begin
            pins.addr <= is_nv ? seq_addr(3'h0, cmd.op) : cmd.addr;
            pins.dq_out <= cmd.wdata;
         end else if (state == nvs_pkg::st_end && next_state == nvs_pkg::st_setup) begin
            pins.addr <= seq_addr(3'(seq_idx + 1'b1), cur.op);
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cmd_ready <= 1'b0;
         busy <= 1'b1;
         rsp_valid <= 1'b0;
         rsp_err <= 1'b0;
         rsp_data <= 8'h00;
      end else begin
         cmd_ready <= next_state == nvs_pkg::st_idle && supply_ok_q;
         busy <= next_state != nvs_pkg::st_idle;
         rsp_err <= state == nvs_pkg::st_idle && accept && cmd.op == nvs_pkg::op_store && !supply_ok_q;
         rsp_valid <= (state == nvs_pkg::st_end && !seq) ||
                      (state == nvs_pkg::st_nvwait && next_state == nvs_pkg::st_idle) ||
                      (state == nvs_pkg::st_idle && accept && cmd.op == nvs_pkg::op_store && !supply_ok_q);
         // Sample late in the strobe so access time and sync delay have passed
         if (state == nvs_pkg::st_strobe && next_state == nvs_pkg::st_end && !seq &&
             cur.op == nvs_pkg::op_read) begin
            rsp_data <= dq_stable;
         end
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   sequence s_read_start;
      $fell(pins.e_n) && pins.w_n && !pins.g_n;
   endsequence
   sequence s_nv_start;
      state == nvs_pkg::st_end && seq && seq_idx == `NVS_SEQ_LAST;
   endsequence

   property p_read_strobe;
      s_read_start |-> (!pins.e_n && !pins.g_n && pins.w_n) [*5] ##1 pins.e_n;
   endproperty
   a_read_strobe: assert property (p_read_strobe) else $error("read strobe shape wrong");
   property p_wr_drive;
      !pins.w_n |-> pins.dq_oe && !pins.e_n && pins.g_n;
   endproperty
   a_wr_drive: assert property (p_wr_drive) else $error("write without driven data");
   property p_wr_addr;
      !pins.w_n && !$past(pins.w_n) |-> $stable(pins.addr);
   endproperty
   a_wr_addr: assert property (p_wr_addr) else $error("address moved in write");
   property p_no_clash;
      !pins.g_n |-> !pins.dq_oe;
   endproperty
   a_no_clash: assert property (p_no_clash) else $error("bus contention");
   property p_seq_w_high;
      seq && !pins.e_n |-> pins.w_n;
   endproperty
   a_seq_w_high: assert property (p_seq_w_high) else $error("write inside sequence");
   property p_seq_order;
      seq && $fell(pins.e_n) |-> pins.addr == seq_addr(seq_idx, cur.op);
   endproperty
   a_seq_order: assert property (p_seq_order) else $error("sequence address wrong");
   property p_no_test;
      seq && !pins.e_n |-> pins.addr != `NVS_SEQ_TEST;
   endproperty
   a_no_test: assert property (p_no_test) else $error("test sequence issued");
   property p_nv_quiet;
      s_nv_start |=> (pins.e_n && pins.w_n) [*8];
   endproperty
   a_nv_quiet: assert property (p_nv_quiet) else $error("access during transfer");
   property p_pwrup;
      state == nvs_pkg::st_pwrup |-> pins.e_n && pins.w_n;
   endproperty
   a_pwrup: assert property (p_pwrup) else $error("access during power-up recall");
   property p_inhibit;
      state == nvs_pkg::st_idle && next_state == nvs_pkg::st_setup && cmd.op == nvs_pkg::op_store |-> supply_ok_q;
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("store with low supply");

endmodule : nvs_host
`default_nettype wire

// *** hdl/nvs_map.svh ***
// Purpose: Constants for the host-side controller of an 8K x 8 nonvolatile SRAM.
// Assumes: 25 MHz clock; pin timing rounded to whole cycles.
// Notes: Times are kept as printed; cycle counts are derived from them.
`ifndef NVS_MAP_SVH
`define NVS_MAP_SVH

`define NVS_CLK_NS 40
`define NVS_ACCESS_NS 45
`define NVS_ACCESS_CYC ((`NVS_ACCESS_NS + `NVS_CLK_NS - 1) / `NVS_CLK_NS)
`define NVS_SYNC_CYC 3
`define NVS_STROBE_CYC (`NVS_ACCESS_CYC + `NVS_SYNC_CYC)
`define NVS_STORE_MS 10
`define NVS_STORE_CYC (`NVS_STORE_MS * 1000000 / `NVS_CLK_NS)
`define NVS_RECALL_US 20
`define NVS_RECALL_CYC (`NVS_RECALL_US * 1000 / `NVS_CLK_NS)
`define NVS_RESTORE_US 650
`define NVS_RESTORE_CYC (`NVS_RESTORE_US * 1000 / `NVS_CLK_NS)
`define NVS_CNT_W 20
`define NVS_SEQ_LAST 3'h5
`define NVS_SEQ_A0 13'h0000
`define NVS_SEQ_A1 13'h1555
`define NVS_SEQ_A2 13'h0AAA
`define NVS_SEQ_A3 13'h1FFF
`define NVS_SEQ_A4 13'h10F0
`define NVS_SEQ_STORE 13'h0F0F
`define NVS_SEQ_RECALL 13'h0F0E
`define NVS_SEQ_TEST 13'h139C

`endif

// *** hdl/nvs_pkg.sv ***
// Purpose: Types for the nonvolatile SRAM host controller.
// Assumes: 13-bit address, 8-bit data.
// Notes: Constants live in nvs_map.svh.
package nvs_pkg;
   typedef enum logic [1:0] {op_read, op_write, op_store, op_recall} nvs_op_t;

   typedef struct packed {
      nvs_op_t op;
      logic [12:0] addr;
      logic [7:0] wdata;
   } nvs_cmd_t;

   typedef struct packed {
      logic e_n;
      logic g_n;
      logic w_n;
      logic [12:0] addr;
      logic [7:0] dq_out;
      logic dq_oe;
   } nvs_pins_t;

   typedef enum {st_pwrup, st_idle, st_setup, st_strobe, st_end, st_nvwait} nvs_state_t;
endpackage : nvs_pkg

// *** test/nvs_host_tb_top.sv ***
// Purpose: Self-checking bench for nvs_host against the behavioural memory.
// Assumes: Short store and power-up waits set through parameters.
// Notes: Sequence aborts cannot be provoked from the command port.
`timescale 1ns/10ps
`default_nettype none

module nvs_host_tb_top;
   logic clock = 1'b0;
   logic rst_n, cmd_valid, supply_ok, cmd_ready, rsp_valid, rsp_err, busy, er;
   logic [7:0] rsp_data, dq, viol, rd;
   nvs_pkg::nvs_cmd_t cmd;
   nvs_pkg::nvs_pins_t pins;
   int err_count = 0;
   int tests_run = 0;
   int cycles = 0;

   nvs_host #(.STORE_CYC(20), .RESTORE_CYC(10)) DUT (.clock(clock), .rst_n(rst_n),
      .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
      .rsp_err(rsp_err), .rsp_data(rsp_data), .busy(busy), .supply_ok(supply_ok),
      .dq_in(dq), .pins(pins));
   nvs_mem_model MEM (.pins(pins), .supply_ok(supply_ok), .dq(dq), .viol(viol));

   task automatic print_verdict;
      if (err_count == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : print_verdict

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   always #20 clock = ~clock;

   // Whole run is under a thousand cycles, so this only trips on a hang
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         err_count++;
         print_verdict();
      end
   end

   task automatic run(input nvs_pkg::nvs_op_t op, input logic [12:0] a, input logic [7:0] d);
      cmd = '{op, a, d};
      cmd_valid = 1'b1;
      while (cmd_ready !== 1'b1) @(posedge clock) #1;
      @(posedge clock) #1;
      cmd_valid = 1'b0;
      while (rsp_valid !== 1'b1) @(posedge clock) #1;
      rd = rsp_data;
      er = rsp_err;
   endtask : run

   task automatic t_reset;
      repeat (16) @(posedge clock);
      check("busy", busy, 1'b1);
      check("cmd_ready", cmd_ready, 1'b0);
      check("w_n", pins.w_n, 1'b1);
      check("dq_oe", pins.dq_oe, 1'b0);
      #1 rst_n = 1'b1;
      supply_ok = 1'b1;
   endtask : t_reset

   task automatic t_rw;
      run(nvs_pkg::op_write, 13'h0000, 8'hA5);
      run(nvs_pkg::op_write, 13'h1FFF, 8'h3C);
      run(nvs_pkg::op_read, 13'h0000, 8'h00);
      check("read 0000", rd, 8'hA5);
      run(nvs_pkg::op_read, 13'h1FFF, 8'h00);
      check("read 1FFF", rd, 8'h3C);
      check("e_n idle", pins.e_n, 1'b1);
   endtask : t_rw

   task automatic t_store_recall;
      run(nvs_pkg::op_store, 13'h0000, 8'h00);
      check("store err", er, 1'b0);
      run(nvs_pkg::op_write, 13'h0000, 8'h11);
      run(nvs_pkg::op_recall, 13'h0000, 8'h00);
      check("recall err", er, 1'b0);
      run(nvs_pkg::op_read, 13'h0000, 8'h00);
      check("recalled 0000", rd, 8'hA5);
      run(nvs_pkg::op_read, 13'h1FFF, 8'h00);
      check("recalled 1FFF", rd, 8'h3C);
   endtask : t_store_recall

   task automatic t_refuse;
      run(nvs_pkg::op_write, 13'h0000, 8'h22);
      // The sync needs four edges; cmd_ready still stands one edge after the drop is seen
      supply_ok = 1'b0;
      repeat (4) @(posedge clock) #1;
      run(nvs_pkg::op_store, 13'h0000, 8'h00);
      check("store refused", er, 1'b1);
      @(posedge clock) #1;
      check("refused e_n", pins.e_n, 1'b1);
      check("busy low supply", busy, 1'b1);
      while (cmd_ready !== 1'b0) @(posedge clock) #1;
      supply_ok = 1'b1;
      run(nvs_pkg::op_read, 13'h0000, 8'h00);
      check("power-up copy", rd, 8'h22);
      check("pin protocol", viol, 8'h00);
   endtask : t_refuse

   initial begin
      rst_n = 1'b0;
      cmd_valid = 1'b0;
      supply_ok = 1'b0;
      cmd = '0;
      t_reset();
      t_rw();
      t_store_recall();
      t_refuse();
      print_verdict();
   end
endmodule : nvs_host_tb_top
`default_nettype wire

// *** test/nvs_mem_model.sv ***
// Purpose: Behavioural 8K x 8 nonvolatile SRAM facing nvs_host.
// Assumes: Transfer times stay below the host's fixed waits.
// Notes: Released data lines flip to the inverse of the last value, never hold a byte.
`timescale 1ns/10ps
`default_nettype none
`include "nvs_map.svh"

module nvs_mem_model #(
   parameter int ACC_NS = 30,
   parameter int STORE_NS = 600,
   parameter int RECALL_NS = 8000,
   parameter int RESTORE_NS = 300
) (
   input wire nvs_pkg::nvs_pins_t pins,
   input wire logic supply_ok,
   output logic [7:0] dq,
   output logic [7:0] viol
);
   logic [7:0] sram [0:8191];
   logic [7:0] nv [0:8191];
   logic [12:0] seq [0:4];
   logic [12:0] a_prev;
   logic [7:0] d_prev;
   logic [2:0] step;
   logic busy, written, wr_prev, rd_prev;

   initial begin
      seq = '{`NVS_SEQ_A0, `NVS_SEQ_A1, `NVS_SEQ_A2, `NVS_SEQ_A3, `NVS_SEQ_A4};
      foreach (nv[i]) nv[i] = 8'h00;
      step = 3'h0;
      busy = 1'b0;
      written = 1'b0;
      wr_prev = 1'b0;
      rd_prev = 1'b0;
      viol = 8'h00;
      dq = 8'h00;
   end

   // The busy flag makes the part deaf during a transfer started by a supply edge; a call from the pin block stalls that block itself
   task automatic transfer(input logic to_nv, input int ns);
      busy = 1'b1;
      step = 3'h0;
      if (to_nv) begin
         foreach (nv[i]) nv[i] = 8'hFF;
         foreach (nv[i]) nv[i] = sram[i];
      end else begin
         foreach (sram[i]) sram[i] = 8'h00;
         foreach (sram[i]) sram[i] = nv[i];
      end
      written = 1'b0;
      #(ns);
      busy = 1'b0;
   endtask : transfer

   always @(pins) begin
      if (!busy) begin
         if (wr_prev && !pins.e_n && !pins.w_n && pins.addr != a_prev) viol = viol + 8'h01;
         if (wr_prev && (pins.e_n || pins.w_n)) begin
            sram[a_prev] = d_prev;
            written = 1'b1;
            step = 3'h0;
         end
         if (rd_prev && pins.e_n) begin
            if (step == 3'h5 && a_prev == `NVS_SEQ_TEST) viol = viol + 8'h01;
            if (step == 3'h5 && a_prev == `NVS_SEQ_STORE && supply_ok) transfer(1'b1, STORE_NS);
            else if (step == 3'h5 && a_prev == `NVS_SEQ_RECALL) transfer(1'b0, RECALL_NS);
            else if (step < 3'h5 && a_prev == seq[step]) step = step + 3'h1;
            else step = (a_prev == `NVS_SEQ_A0) ? 3'h1 : 3'h0;
         end
         wr_prev = !pins.e_n && !pins.w_n;
         rd_prev = !pins.e_n && pins.w_n;
         a_prev = pins.addr;
         d_prev = pins.dq_out;
      end
   end

   always @(pins or busy) begin
      if (!busy && !pins.e_n && !pins.g_n && pins.w_n) dq <= #(ACC_NS) sram[pins.addr];
      else dq <= ~dq;
   end

   always @(negedge supply_ok) begin
      if (written) transfer(1'b1, 0);
   end

   always @(posedge supply_ok) begin
      transfer(1'b0, RESTORE_NS);
      if (!pins.e_n && !pins.w_n) viol = viol + 8'h01;
   end
endmodule : nvs_mem_model
`default_nettype wire
